// >>> rtl/mdu_divider_dev.sv
/*
 * Divide unit: six operand byte registers whose access order selects a
 * 32/16 or 16/16 unsigned division, a sequence tracker and a status byte.
 * Assumes a single master issuing at most one access of each kind a cycle.
 */
// Notes on behaviour
// - Load, execute, then read back, in order.
// - Software keeps the exact access order.
// - Byte 0 write restarts and arms error.
// - Divisor high byte write starts division.
// - Dividend bytes written into 0..3 ascending.
// - Short form uses bytes 0 and 1 only.
// - Divisor low then high into 4, 5.
// - Quotient in bytes 0..3, read ascending.
// - Remainder low byte sits in byte 4.
// - Final read closes the operation.
// - Bytes 1..5 read/write, reset to zero.
// - Remainder high in byte 5, then status.
// - Error flag on bad write, cleared on completion.
// - Overflow flag on zero divisor.
`timescale 1ns/1ps
`default_nettype none

module mdu_divider_dev
    import mdu_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    mdu_if.dev       bus
);

    typedef enum logic [3:0] {
        S_IDLE, S_W1, S_W2, S_W3, S_W4, S_W5, S_CALC,
        S_R0, S_R1, S_R2, S_R3, S_R4, S_R5
    } mdu_seq_t;

    mdu_seq_t    st_q;
    logic        wide_q;
    logic        err_q;
    logic        ovf_q;
    logic [7:0]  md_q [6];
    logic        busy_q;
    logic [5:0]  cnt_q;
    logic [31:0] quo_q;
    logic [15:0] rem_q;
    logic [15:0] dvs_q;

    logic        wr_md;
    logic        rd_md;
    logic [2:0]  widx;
    logic        start;
    logic        fin;
    logic [16:0] trial;
    logic [16:0] diff;
    logic [31:0] step_quo;
    logic [15:0] step_rem;
    logic [47:0] step_res;
    logic        err_set;
    logic        err_clr;

    assign widx  = 3'(bus.sfr_addr - ADDR_OPERAND_BYTE0);
    assign wr_md = bus.sfr_wr && bus.sfr_addr >= ADDR_OPERAND_BYTE0
                   && bus.sfr_addr <= ADDR_OPERAND_BYTE5;
    assign rd_md = bus.sfr_rd && bus.sfr_addr >= ADDR_OPERAND_BYTE0
                   && bus.sfr_addr <= ADDR_OPERAND_BYTE5;

    assign start = st_q == S_W5 && wr_md && widx == STEP_DIVISOR_HI;
    assign fin   = busy_q && cnt_q == 6'h01 && !wr_md;

    assign trial    = {rem_q, quo_q[31]};
    assign diff     = trial - {1'b0, dvs_q};
    assign step_quo = {quo_q[30:0], !diff[16]};
    assign step_rem = diff[16] ? trial[15:0] : diff[15:0];
    assign step_res = {step_rem, step_quo};

    // Any operand write while an operation is open breaks it, except the
    // expected next byte; a byte 0 write restarts and is also a break.
    always_comb begin
        err_set = 1'b0;
        if (wr_md && st_q != S_IDLE) begin
            case (st_q)
                S_W1:    err_set = widx != 3'h1;
                S_W2:    err_set = widx != 3'h2 && widx != STEP_DIVISOR_LO;
                S_W3:    err_set = widx != 3'h3;
                S_W4:    err_set = widx != STEP_DIVISOR_LO;
                S_W5:    err_set = widx != STEP_DIVISOR_HI;
                default: err_set = 1'b1;
            endcase
        end
    end

    assign err_clr = st_q == S_R5 && rd_md && widx == STEP_DIVISOR_HI;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q   <= S_IDLE;
            wide_q <= 1'b0;
        end else if (wr_md && widx == 3'h0) begin
            st_q <= S_W1;
        end else if (err_set) begin
            st_q <= S_IDLE;
        end else if (wr_md) begin
            case (st_q)
                S_W1: st_q <= S_W2;
                S_W2: begin
                    wide_q <= widx == 3'h2;
                    st_q   <= widx == 3'h2 ? S_W3 : S_W5;
                end
                S_W3:    st_q <= S_W4;
                S_W4:    st_q <= S_W5;
                S_W5:    st_q <= S_CALC;
                default: st_q <= st_q;
            endcase
        end else if (st_q == S_CALC && fin) begin
            st_q <= S_R0;
        end else if (rd_md) begin
            case (st_q)
                S_R0: st_q <= widx == 3'h0 ? S_R1 : st_q;
                S_R1: begin
                    if (widx == 3'h1) begin
                        st_q <= wide_q ? S_R2 : S_R4;
                    end
                end
                S_R2: st_q <= widx == 3'h2 ? S_R3 : st_q;
                S_R3: st_q <= widx == 3'h3 ? S_R4 : st_q;
                S_R4: st_q <= widx == STEP_DIVISOR_LO ? S_R5 : st_q;
                S_R5: st_q <= widx == STEP_DIVISOR_HI ? S_IDLE : st_q;
                default: st_q <= st_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_q <= 1'b0;
        end else begin
            err_q <= (err_q && !err_clr) || err_set;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 6'h00;
            quo_q  <= 32'h0000_0000;
            rem_q  <= 16'h0000;
            dvs_q  <= 16'h0000;
            ovf_q  <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= DIV_STEPS;
            rem_q  <= 16'h0000;
            dvs_q  <= {bus.sfr_wdata, md_q[4]};
            // short dividend from bytes 0, 1
            quo_q  <= wide_q ? {md_q[3], md_q[2], md_q[1], md_q[0]}
                             : {16'h0000, md_q[1], md_q[0]};
            ovf_q  <= {bus.sfr_wdata, md_q[4]} == 16'h0000;
        end else if (busy_q && wr_md) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            quo_q  <= step_quo;
            rem_q  <= step_rem;
            cnt_q  <= cnt_q - 6'h01;
            busy_q <= cnt_q != 6'h01;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_md
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    md_q[gi] <= OPERAND_RESET;
                end else if (wr_md && widx == 3'(gi)) begin
                    // divisor bytes land in 4, 5
                    md_q[gi] <= bus.sfr_wdata;
                end else if (fin) begin
                    md_q[gi] <= step_res[gi*8 +: 8];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus.sfr_rdata  <= UNMAPPED_READ;
            bus.sfr_rvalid <= 1'b0;
        end else begin
            bus.sfr_rvalid <= bus.sfr_rd;
            if (rd_md) begin
                bus.sfr_rdata <= md_q[widx];
            end else if (bus.sfr_addr == ADDR_ARITH_CONTROL) begin
                bus.sfr_rdata <= UNMAPPED_READ;
                bus.sfr_rdata[SEQ_ERR_BIT] <= err_q;
                bus.sfr_rdata[OVF_BIT]     <= ovf_q;
            end else begin
                bus.sfr_rdata <= UNMAPPED_READ;
            end
        end
    end

    assign bus.busy = busy_q;

endmodule : mdu_divider_dev

`default_nettype wire

// >>> rtl/mdu_pkg.sv
/*
 * Shared constants for the divide unit and its register-bus master:
 * register addresses, status bit positions, reset values and step counts.
 * Assumes an 8-bit register bus with byte-wide, single-cycle accesses.
 */
package mdu_pkg;

    localparam logic [7:0] ADDR_OPERAND_BYTE0 = 8'hF9;
    localparam logic [7:0] ADDR_OPERAND_BYTE1 = 8'hFA;
    localparam logic [7:0] ADDR_OPERAND_BYTE2 = 8'hFB;
    localparam logic [7:0] ADDR_OPERAND_BYTE3 = 8'hFC;
    localparam logic [7:0] ADDR_OPERAND_BYTE4 = 8'hFD;
    localparam logic [7:0] ADDR_OPERAND_BYTE5 = 8'hFE;
    localparam logic [7:0] ADDR_ARITH_CONTROL = 8'hFF;

    localparam int         SEQ_ERR_BIT        = 7;
    localparam int         OVF_BIT            = 6;

    localparam logic [7:0] OPERAND_RESET      = 8'h00;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    localparam logic [5:0] DIV_STEPS          = 6'h20;
    localparam logic [2:0] STEP_DIVISOR_LO    = 3'h4;
    localparam logic [2:0] STEP_DIVISOR_HI    = 3'h5;
    localparam logic [2:0] STEP_CONTROL       = 3'h6;

endpackage : mdu_pkg

// >>> rtl/mdu_if.sv
/*
 * Register bus between the CPU-side master and the divide unit.
 * Assumes one clock; the master drives address, strobes and write data,
 * the unit answers with registered read data and a busy level.
 */
`timescale 1ns/1ps
`default_nettype none

interface mdu_if;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       sfr_rvalid;
    logic       busy;

    modport dev (
        input  sfr_addr,
        input  sfr_wr,
        input  sfr_rd,
        input  sfr_wdata,
        output sfr_rdata,
        output sfr_rvalid,
        output busy
    );

    modport host (
        output sfr_addr,
        output sfr_wr,
        output sfr_rd,
        output sfr_wdata,
        input  sfr_rdata,
        input  sfr_rvalid,
        input  busy
    );
endinterface : mdu_if

`default_nettype wire

// >>> rtl/mdu_divider_host.sv
/*
 * Register-bus master for the divide unit: takes one division request,
 * writes the operands in the required order, waits out the busy level,
 * reads quotient, remainder and status back, then reports the result.
 * Assumes the unit answers each read one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module mdu_divider_host
    import mdu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    mdu_if.host              bus,
    input  wire logic        req_start,
    input  wire logic        req_wide,
    input  wire logic [31:0] req_dividend,
    input  wire logic [15:0] req_divisor,
    output var  logic        req_ready,
    output var  logic        res_valid,
    output var  logic [31:0] res_quotient,
    output var  logic [15:0] res_remainder,
    output var  logic        res_seq_err,
    output var  logic        res_ovf
);

    typedef enum logic [2:0] {
        H_IDLE, H_WR, H_GAP, H_WAIT, H_RD, H_RDW
    } mdu_host_t;

    mdu_host_t   st_q;
    logic [2:0]  step_q;
    logic        wide_q;
    logic [47:0] opnd_q;
    logic [2:0]  next_step;

    // short form skips bytes 2 and 3
    assign next_step = (step_q == 3'h1 && !wide_q) ? STEP_DIVISOR_LO
                                                   : step_q + 3'h1;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q          <= H_IDLE;
            step_q        <= 3'h0;
            wide_q        <= 1'b0;
            opnd_q        <= 48'h0000_0000_0000;
            req_ready     <= 1'b1;
            res_valid     <= 1'b0;
            res_quotient  <= 32'h0000_0000;
            res_remainder <= 16'h0000;
            res_seq_err   <= 1'b0;
            res_ovf       <= 1'b0;
            bus.sfr_addr  <= 8'h00;
            bus.sfr_wr    <= 1'b0;
            bus.sfr_rd    <= 1'b0;
            bus.sfr_wdata <= 8'h00;
        end else begin
            res_valid  <= 1'b0;
            bus.sfr_wr <= 1'b0;
            bus.sfr_rd <= 1'b0;
            case (st_q)
                H_IDLE: begin
                    if (req_start) begin
                        opnd_q    <= {req_divisor, req_dividend};
                        wide_q    <= req_wide;
                        step_q    <= 3'h0;
                        req_ready <= 1'b0;
                        st_q      <= H_WR;
                    end
                end
                H_WR: begin
                    bus.sfr_wr    <= 1'b1;
                    bus.sfr_addr  <= ADDR_OPERAND_BYTE0 + 8'(step_q);
                    bus.sfr_wdata <= opnd_q[6'(step_q) * 6'd8 +: 8];
                    step_q        <= next_step;
                    if (step_q == STEP_DIVISOR_HI) begin
                        st_q <= H_GAP;
                    end
                end
                H_GAP: begin
                    step_q <= 3'h0;
                    st_q   <= H_WAIT;
                end
                H_WAIT: begin
                    if (!bus.busy) begin
                        st_q <= H_RD;
                    end
                end
                H_RD: begin
                    bus.sfr_rd   <= 1'b1;
                    bus.sfr_addr <= step_q == STEP_CONTROL
                                    ? ADDR_ARITH_CONTROL
                                    : ADDR_OPERAND_BYTE0 + 8'(step_q);
                    st_q         <= H_RDW;
                end
                H_RDW: begin
                    if (bus.sfr_rvalid) begin
                        if (step_q == STEP_CONTROL) begin
                            res_seq_err <= bus.sfr_rdata[SEQ_ERR_BIT];
                            res_ovf     <= bus.sfr_rdata[OVF_BIT];
                            res_valid   <= 1'b1;
                            req_ready   <= 1'b1;
                            st_q        <= H_IDLE;
                        end else begin
                            if (step_q < STEP_DIVISOR_LO) begin
                                res_quotient[5'(step_q) * 5'd8 +: 8]
                                    <= bus.sfr_rdata;
                            end else begin
                                res_remainder[(step_q == STEP_DIVISOR_HI)
                                              * 8 +: 8] <= bus.sfr_rdata;
                            end
                            if (step_q == 3'h1 && !wide_q) begin
                                res_quotient[31:16] <= 16'h0000;
                            end
                            step_q <= next_step;
                            st_q   <= H_RD;
                        end
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

endmodule : mdu_divider_host

`default_nettype wire

// >>> verif/mdu_bus_monitor.sv
/*
 * Checker for the link between master and divide unit: read answer, busy
 * timing, status bits and the order of the master's divisor writes.
 * Assumes plain connections to the interface signals and one clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mdu_bus_monitor
    import mdu_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_rvalid,
    input wire logic       busy
);
    logic [7:0]  busy_cnt_q;
    logic [7:0]  last_wr_q;
    logic [15:0] divisor_q;
    logic        ovf_exp_q;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) busy_cnt_q <= 8'h00;
        else busy_cnt_q <= busy ? busy_cnt_q + 8'h01 : 8'h00;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) last_wr_q <= 8'h00;
        else if (sfr_wr) last_wr_q <= sfr_addr;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) divisor_q <= 16'h0000;
        else if (sfr_wr && sfr_addr == ADDR_OPERAND_BYTE4)
            divisor_q[7:0] <= sfr_wdata;
        else if (sfr_wr && sfr_addr == ADDR_OPERAND_BYTE5)
            divisor_q[15:8] <= sfr_wdata;
    end

    // The overflow bit follows the divisor of the last started division.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) ovf_exp_q <= 1'b0;
        else if ($rose(busy)) ovf_exp_q <= (divisor_q == 16'h0000);
    end

    AST_READ_ANSWER: assert property (sfr_rd |=> sfr_rvalid)
        else $error("read strobe not answered");
    AST_NO_STRAY_VALID: assert property (!sfr_rd |=> !sfr_rvalid)
        else $error("read valid without strobe");
    AST_START_CAUSE: assert property ($rose(busy) |->
        $past(sfr_wr) && $past(sfr_addr) == ADDR_OPERAND_BYTE5)
        else $error("busy rose without divisor high write");
    AST_DIV_LENGTH: assert property (
        $fell(busy) && !$past(sfr_wr) |-> busy_cnt_q == {2'b00, DIV_STEPS})
        else $error("division length wrong");
    AST_STATUS_SPARE: assert property ($past(sfr_rd) &&
        $past(sfr_addr) == ADDR_ARITH_CONTROL |-> sfr_rdata[5:0] == 6'h00)
        else $error("status spare bits set");
    AST_OVF_ZERO: assert property ($past(sfr_rd) &&
        $past(sfr_addr) == ADDR_ARITH_CONTROL |->
        sfr_rdata[OVF_BIT] == ovf_exp_q)
        else $error("overflow bit wrong");
    AST_HOST_WAITS: assert property (busy |-> !sfr_rd && !sfr_wr)
        else $error("access while busy");
    AST_DIVISOR_LOW_ORDER: assert property (
        sfr_wr && sfr_addr == ADDR_OPERAND_BYTE4 |->
        last_wr_q == ADDR_OPERAND_BYTE1 || last_wr_q == ADDR_OPERAND_BYTE3)
        else $error("divisor low byte out of order");
    AST_DIVISOR_HIGH_ORDER: assert property (
        sfr_wr && sfr_addr == ADDR_OPERAND_BYTE5 |->
        last_wr_q == ADDR_OPERAND_BYTE4)
        else $error("divisor high byte out of order");
endmodule : mdu_bus_monitor

`default_nettype wire

// >>> verif/tb.sv
/*
 * Testbench: master and divide unit joined by one interface, plus a
 * second unit driven directly by the bench to reach misuse cases.
 * Assumes the package and interface are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
    import mdu_pkg::*;
;
    logic        core_clk;
    logic        sys_rst;
    logic        req_start;
    logic        req_wide;
    logic [31:0] req_dividend;
    logic [15:0] req_divisor;
    logic        req_ready;
    logic        res_valid;
    logic [31:0] res_quotient;
    logic [15:0] res_remainder;
    logic        res_seq_err;
    logic        res_ovf;
    logic [31:0] q_exp;
    logic [15:0] r_exp;
    int          n_mismatch = 0;
    int          checks = 0;

    mdu_if i_link ();
    mdu_if i_probe ();

    mdu_divider_dev u_mdu_divider_dev (
        .core_clk (core_clk), .sys_rst (sys_rst), .bus (i_link.dev));
    mdu_divider_dev u_mdu_divider_dev_2 (
        .core_clk (core_clk), .sys_rst (sys_rst), .bus (i_probe.dev));
    mdu_divider_host u_mdu_divider_host (
        .core_clk (core_clk), .sys_rst (sys_rst), .bus (i_link.host),
        .req_start (req_start), .req_wide (req_wide),
        .req_dividend (req_dividend), .req_divisor (req_divisor),
        .req_ready (req_ready), .res_valid (res_valid),
        .res_quotient (res_quotient), .res_remainder (res_remainder),
        .res_seq_err (res_seq_err), .res_ovf (res_ovf));
    mdu_bus_monitor u_mdu_bus_monitor (
        .core_clk (core_clk), .sys_rst (sys_rst),
        .sfr_addr (i_link.sfr_addr), .sfr_wr (i_link.sfr_wr),
        .sfr_rd (i_link.sfr_rd), .sfr_wdata (i_link.sfr_wdata),
        .sfr_rdata (i_link.sfr_rdata), .sfr_rvalid (i_link.sfr_rvalid),
        .busy (i_link.busy));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task automatic drv(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
        i_probe.sfr_wr    <= w;
        i_probe.sfr_rd    <= r;
        i_probe.sfr_addr  <= a;
        i_probe.sfr_wdata <= d;
        @(posedge core_clk);
    endtask : drv

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        drv(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        drv(1'b0, 1'b1, a, 8'h00);
        i_probe.sfr_rd <= 1'b0;
        @(negedge core_clk);
        chk(i_probe.sfr_rvalid, 1'b1);
        chk(i_probe.sfr_rdata, exp);
        @(posedge core_clk);
    endtask : rd

    task automatic wait_idle();
        int n;
        drv(1'b0, 1'b0, 8'h00, 8'h00);
        n = 0;
        @(negedge core_clk);
        while (i_probe.busy !== 1'b0 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        chk(i_probe.busy, 1'b0);
        @(posedge core_clk);
    endtask : wait_idle

    task automatic run(input logic wide, input logic [31:0] dvd,
                       input logic [15:0] dvs);
        int          n;
        logic [31:0] x;
        x = wide ? dvd : {16'h0000, dvd[15:0]};
        n = 0;
        @(negedge core_clk);
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        chk(req_ready, 1'b1);
        @(posedge core_clk);
        req_start    <= 1'b1;
        req_wide     <= wide;
        req_dividend <= dvd;
        req_divisor  <= dvs;
        @(posedge core_clk);
        req_start <= 1'b0;
        n = 0;
        while (res_valid !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        chk(res_valid, 1'b1);
        chk(res_ovf, dvs == 16'h0000);
        chk(res_seq_err, 1'b0);
        if (dvs != 16'h0000) begin
            chk(res_quotient, x / dvs);
            chk(res_remainder, 16'(x % dvs));
        end
    endtask : run

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        sys_rst      <= 1'b1;
        req_start    <= 1'b0;
        req_wide     <= 1'b0;
        req_dividend <= 32'h0000_0000;
        req_divisor  <= 16'h0000;
        drv(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++)
            rd(ADDR_OPERAND_BYTE0 + 8'(i), OPERAND_RESET);
        rd(8'h10, UNMAPPED_READ);
        for (int i = 1; i < 6; i++)
            wr(ADDR_OPERAND_BYTE0 + 8'(i), 8'(8'h11 * i));
        for (int i = 1; i < 6; i++)
            rd(ADDR_OPERAND_BYTE0 + 8'(i), 8'(8'h11 * i));
        wr(ADDR_OPERAND_BYTE0, 8'h05);
        wr(ADDR_OPERAND_BYTE1, 8'h10);
        wr(ADDR_OPERAND_BYTE4, 8'h10);
        wr(ADDR_OPERAND_BYTE5, 8'h00);
        wait_idle();
        rd(ADDR_OPERAND_BYTE0, 8'h00);
        rd(ADDR_OPERAND_BYTE1, 8'h01);
        rd(ADDR_OPERAND_BYTE4, 8'h05);
        rd(ADDR_OPERAND_BYTE5, 8'h00);
        rd(ADDR_ARITH_CONTROL, 8'h00);
        wr(ADDR_OPERAND_BYTE0, 8'hAA);
        wr(ADDR_OPERAND_BYTE1, 8'hBB);
        wr(ADDR_OPERAND_BYTE0, 8'h00);
        drv(1'b0, 1'b0, 8'h00, 8'h00);
        rd(ADDR_ARITH_CONTROL, 8'h80);
        wr(ADDR_OPERAND_BYTE1, 8'h20);
        wr(ADDR_OPERAND_BYTE2, 8'h30);
        wr(ADDR_OPERAND_BYTE3, 8'h40);
        wr(ADDR_OPERAND_BYTE4, 8'h03);
        wr(ADDR_OPERAND_BYTE5, 8'h01);
        wait_idle();
        q_exp = 32'h4030_2000 / 32'h0000_0103;
        r_exp = 16'(32'h4030_2000 % 32'h0000_0103);
        for (int i = 0; i < 4; i++)
            rd(ADDR_OPERAND_BYTE0 + 8'(i), q_exp[8*i +: 8]);
        rd(ADDR_OPERAND_BYTE4, r_exp[7:0]);
        rd(ADDR_OPERAND_BYTE5, r_exp[15:8]);
        rd(ADDR_ARITH_CONTROL, 8'h00);
        wr(ADDR_OPERAND_BYTE0, 8'h09);
        wr(ADDR_OPERAND_BYTE1, 8'h00);
        wr(ADDR_OPERAND_BYTE4, 8'h01);
        wr(ADDR_OPERAND_BYTE5, 8'h00);
        drv(1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge core_clk);
        chk(i_probe.busy, 1'b1);
        @(posedge core_clk);
        rd(ADDR_OPERAND_BYTE4, 8'h01);
        wr(ADDR_OPERAND_BYTE4, 8'h02);
        drv(1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge core_clk);
        chk(i_probe.busy, 1'b0);
        @(posedge core_clk);
        rd(ADDR_ARITH_CONTROL, 8'h80);
        run(1'b1, 32'hFEDC_BA98, 16'h1234);
        run(1'b0, 32'hABCD_1005, 16'h0010);
        run(1'b1, 32'hFFFF_FFFF, 16'hFFFF);
        run(1'b0, 32'h0000_4321, 16'h0000);
        run(1'b1, 32'h0000_0007, 16'h0009);
        end_sim();
    end
endmodule : tb

`default_nettype wire
